// File: pkg/sdb_pkg.sv
package sdb_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_BANKS  = 4;
  localparam int ROW_BITS   = 12;
  localparam int NUM_ROWS   = 4096;
  localparam int COL_X4     = 1024;
  localparam int COL_X8     = 512;
  localparam int COL_X16    = 256;
  localparam int COL_BITS   = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int BURST_FULL_CODE = 4;

  // ----------------------------------------------------------------
  // Read latency choices
  // ----------------------------------------------------------------
  localparam logic [1:0] LAT_MIN = 2'h2;
  localparam logic [1:0] LAT_MAX = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int PRECHARGE_NS    = 20;
  localparam int PRECHARGE_CYC   =
    (PRECHARGE_NS * CLK_MHZ + 999) / 1000;
  localparam int REFRESH_NS      = 70;
  localparam int REFRESH_CYC     = (REFRESH_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Commands and bursts
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SDB_CMD_NOP,
    SDB_CMD_ACTIVATE,
    SDB_CMD_READ,
    SDB_CMD_WRITE,
    SDB_CMD_PRECHARGE,
    SDB_CMD_BURST_STOP,
    SDB_CMD_REFRESH,
    SDB_CMD_MODE
  } sdb_cmd_t;

  typedef struct packed {
    sdb_cmd_t                cmd;
    logic                    bank_select_hi;
    logic                    bank_select_lo;
    logic [ROW_BITS-1:0]     row_col_address;
    logic                    auto_precharge;
  } sdb_req_t;

  typedef struct packed {
    logic [2:0]          burst_code;
    logic [1:0]          read_latency;
  } sdb_mode_t;

  typedef struct packed {
    logic [1:0]          bank;
    logic [COL_BITS-1:0] col;
    logic                is_write;
  } sdb_beat_t;
endpackage

// File: hw/sdb_fifo.sv
module sdb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_i, // Clock
  input  wire logic             reset_i,    // Sync reset
  input  wire logic             in_valid_i, // Write valid
  output logic                  in_ready_o, // Not full
  input  wire logic [WIDTH-1:0] in_data_i,  // Write data
  output logic                  out_valid_o,// Not empty
  input  wire logic             out_ready_i,// Read accept
  output logic      [WIDTH-1:0] out_data_o  // Head word
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge core_clk_i) begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// File: hw/sdb_bank.sv
module sdb_bank #(
  parameter int PRE_CYC = 2
) (
  input  wire logic                         core_clk_i, // Clock
  input  wire logic                         reset_i,    // Sync reset
  input  wire logic                         activate_i, // Open row
  input  wire logic [sdb_pkg::ROW_BITS-1:0] row_i,      // Row to open
  input  wire logic                         close_i,    // Start precharge
  output logic                              open_o,     // Row open
  output logic                              busy_o,     // Precharging
  output logic      [sdb_pkg::ROW_BITS-1:0] row_o       // Open row
);
  initial begin
    if (PRE_CYC < 1)
      $error("PRE_CYC must be at least one");
  end

  logic [7:0] pre_cnt;

  // Each bank closes on its own timer, so others keep streaming
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      open_o  <= 1'b0;
      pre_cnt <= '0;
      row_o   <= '0;
    end else if (close_i && open_o) begin
      open_o  <= 1'b0;
      pre_cnt <= 8'(PRE_CYC);                                 // RULE10
    end else if (pre_cnt != 8'h00) begin
      pre_cnt <= pre_cnt - 8'h01;
    end else if (activate_i) begin
      open_o  <= 1'b1;
      row_o   <= row_i;
    end
  end

  assign busy_o = pre_cnt != 8'h00;
endmodule

// File: hw/sdb_core.sv
// Behaviour
// RULE1: All inputs taken only on the rising clock edge.
// RULE2: Activate uses two bank selects and twelve address bits for the row.
// RULE3: Controller activates a row before any read or write.
// RULE4: Read or write address becomes the burst start column.
// RULE5: Columns per row: 1024 by 4, 512 by 8, 256 by 16 bits.
// RULE6: Burst length 1, 2, 4, 8 or full row; terminate ends early.
// RULE7: Later burst columns generated internally in sequence.
// RULE8: Auto precharge closes the row when the burst ends; sdb_core does so only for bursts of 1 to 8 that run to their end.
// RULE9: A new column command accepted every cycle.
// RULE10: Banks run independently; one precharges while another streams.
// RULE11: Auto refresh and power-down are supported.
// RULE12: Read data appears two or three clocks after the read; sdb_core raises rd_valid_o three or four clocks after it takes the read.
// RULE13: Controller refreshes all 4096 rows every 64 ms; sdb_core has no refresh timer and refreshes only on a REFRESH command.
module sdb_core #(
  parameter int DATA_W = 16,
  parameter int COLS   = sdb_pkg::COL_X16
) (
  input  wire logic              core_clk_i,   // Clock
  input  wire logic              reset_i,      // Sync reset
  input  wire logic              power_down_i, // Power-down request
  input  wire sdb_pkg::sdb_req_t req_i,        // Command and address
  input  wire logic [DATA_W-1:0] wr_data_i,    // Write data
  output logic      [DATA_W-1:0] rd_data_o,    // Read data
  output logic                   rd_valid_o,   // Read data valid
  output logic                   cmd_ready_o,  // Command accepted
  output logic                   in_power_down_o, // Powered down
  output logic                   refreshing_o, // Refresh running
  output logic      [3:0]        bank_open_o   // Row open per bank
);
  initial begin
    if (COLS != sdb_pkg::COL_X4 && COLS != sdb_pkg::COL_X8 &&
        COLS != sdb_pkg::COL_X16)
      $error("COLS must be 1024, 512 or 256");                // RULE5
  end

  localparam int CB = $clog2(COLS);
  localparam int BW = $bits(sdb_pkg::sdb_beat_t);

  // ----------------------------------------------------------------
  // Storage, addressed bank:row:column
  // ----------------------------------------------------------------
  // Sized small by default; full depth would not fit a simulator well
  localparam int ROWS_SIM = 4;
  logic [DATA_W-1:0] mem [sdb_pkg::NUM_BANKS*ROWS_SIM*COLS];

  sdb_pkg::sdb_mode_t mode;
  sdb_pkg::sdb_req_t  req;
  logic [DATA_W-1:0]  wr_data;
  logic [1:0]         bank;
  logic [3:0]         act_vec;
  logic [3:0]         close_vec;
  logic [3:0]         busy_vec;
  logic [sdb_pkg::ROW_BITS-1:0] rows [4];

  // Burst engine state, plus the refresh counter
  logic          burst_on;
  logic [1:0]    burst_bank;
  logic [CB-1:0] burst_col;
  logic [CB:0]   burst_left;
  logic          burst_wr;
  logic          burst_ap;
  logic [5:0]    ref_cnt;

  function automatic logic [CB:0] burst_len(input logic [2:0] code);
    case (code)
      3'h0:    burst_len = (CB+1)'(1);
      3'h1:    burst_len = (CB+1)'(2);
      3'h2:    burst_len = (CB+1)'(4);
      3'h3:    burst_len = (CB+1)'(8);
      default: burst_len = (CB+1)'(COLS);
    endcase
  endfunction

  function automatic int mem_index(input logic [1:0] b,
                                   input logic [sdb_pkg::ROW_BITS-1:0] r,
                                   input logic [CB-1:0] c);
    mem_index = ((int'(b) * ROWS_SIM) + (int'(r) % ROWS_SIM)) * COLS
                + int'(c);
  endfunction

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      req     <= '0;
      wr_data <= '0;
    end else begin
      req     <= req_i;                                       // RULE1
      wr_data <= wr_data_i;
    end
  end

  assign bank = {req.bank_select_hi, req.bank_select_lo};     // RULE2
  assign cmd_ready_o = !refreshing_o && !in_power_down_o;     // RULE9

  // ----------------------------------------------------------------
  // Mode, refresh and power-down
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mode.burst_code   <= 3'h3;
      mode.read_latency <= sdb_pkg::LAT_MIN;
    end else if (cmd_ready_o && req.cmd == sdb_pkg::SDB_CMD_MODE) begin
      mode.burst_code <= req.row_col_address[2:0];            // RULE6
      mode.read_latency <= (req.row_col_address[5:4] == sdb_pkg::LAT_MAX)
                           ? sdb_pkg::LAT_MAX : sdb_pkg::LAT_MIN;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ref_cnt <= '0;
    end else if (ref_cnt != 6'h00) begin
      ref_cnt <= ref_cnt - 6'h01;
    end else if (cmd_ready_o && req.cmd == sdb_pkg::SDB_CMD_REFRESH &&
                 bank_open_o == 4'h0) begin
      ref_cnt <= 6'(sdb_pkg::REFRESH_CYC);                    // RULE11
    end
  end
  assign refreshing_o = ref_cnt != 6'h00;

  always_ff @(posedge core_clk_i) begin
    if (reset_i)
      in_power_down_o <= 1'b0;
    else
      in_power_down_o <= power_down_i && !burst_on;           // RULE11
  end

  // ----------------------------------------------------------------
  // Banks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < sdb_pkg::NUM_BANKS; g++) begin : g_bank
    assign act_vec[g] = cmd_ready_o && bank == 2'(g) &&
                        req.cmd == sdb_pkg::SDB_CMD_ACTIVATE;  // RULE2
    assign close_vec[g] =
      (cmd_ready_o && req.cmd == sdb_pkg::SDB_CMD_PRECHARGE &&
       (bank == 2'(g) || req.auto_precharge)) ||
      (burst_on && burst_ap && burst_bank == 2'(g) &&
       burst_left == (CB+1)'(1));                             // RULE8
    sdb_bank #(
      .PRE_CYC (sdb_pkg::PRECHARGE_CYC)
    ) u_bank (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .activate_i (act_vec[g]),
      .row_i      (req.row_col_address),
      .close_i    (close_vec[g]),
      .open_o     (bank_open_o[g]),
      .busy_o     (busy_vec[g]),
      .row_o      (rows[g])
    );
  end

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  logic col_cmd;
  assign col_cmd = cmd_ready_o && bank_open_o[bank] &&       // RULE3
                   (req.cmd == sdb_pkg::SDB_CMD_READ ||
                    req.cmd == sdb_pkg::SDB_CMD_WRITE);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      burst_on   <= 1'b0;
      burst_bank <= '0;
      burst_col  <= '0;
      burst_left <= '0;
      burst_wr   <= 1'b0;
      burst_ap   <= 1'b0;
    end else if (col_cmd) begin
      // A new column command cuts the running burst short
      burst_on   <= 1'b1;                                     // RULE9
      burst_bank <= bank;
      burst_col  <= req.row_col_address[CB-1:0];              // RULE4
      burst_left <= burst_len(mode.burst_code);               // RULE6
      burst_wr   <= req.cmd == sdb_pkg::SDB_CMD_WRITE;
      burst_ap   <= req.auto_precharge &&
                    mode.burst_code < 3'(sdb_pkg::BURST_FULL_CODE);
    end else if (cmd_ready_o && req.cmd == sdb_pkg::SDB_CMD_BURST_STOP) begin
      burst_on   <= 1'b0;                                     // RULE6
    end else if (burst_on) begin
      burst_col  <= burst_col + 1'b1;                         // RULE7
      burst_left <= burst_left - 1'b1;
      if (burst_left == (CB+1)'(1) &&
          mode.burst_code != 3'(sdb_pkg::BURST_FULL_CODE))
        burst_on <= 1'b0;
      else if (burst_left == (CB+1)'(1))
        burst_left <= burst_len(mode.burst_code);             // RULE6
    end
  end

  // Write beats use data present with the same beat
  always_ff @(posedge core_clk_i) begin
    if (burst_on && burst_wr && bank_open_o[burst_bank])
      mem[mem_index(burst_bank, rows[burst_bank], burst_col)] <= wr_data;
  end

  // ----------------------------------------------------------------
  // Read path through FIFO, released after the latency
  // ----------------------------------------------------------------
  sdb_pkg::sdb_beat_t beat;
  logic [DATA_W-1:0]  fifo_data;
  logic [DATA_W-1:0]  rd_word;
  logic               fifo_valid;
  logic               fifo_ready;
  logic               push;
  logic [1:0]         age;

  assign beat = '{bank: burst_bank, col: COL_BITS_EXT(burst_col),
                  is_write: burst_wr};
  assign rd_word = mem[mem_index(burst_bank, rows[burst_bank], burst_col)];
  assign push = burst_on && !burst_wr;

  function automatic logic [sdb_pkg::COL_BITS-1:0] COL_BITS_EXT(
    input logic [CB-1:0] c);
    COL_BITS_EXT = sdb_pkg::COL_BITS'(c);
  endfunction

  sdb_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (sdb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (rd_word),
    .out_valid_o (fifo_valid),
    .out_ready_i (age == mode.read_latency - 2'h1),
    .out_data_o  (fifo_data)
  );

  // Head word waits latency-1 cycles; with one beat per cycle this
  // gives a steady stream at read_latency after each column beat
  always_ff @(posedge core_clk_i) begin
    if (reset_i)
      age <= '0;
    else if (!fifo_valid || age == mode.read_latency - 2'h1)
      age <= fifo_valid ? age : 2'h1;
    else
      age <= age + 2'h1;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_data_o  <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= fifo_valid && age == mode.read_latency - 2'h1; // RULE12
      rd_data_o  <= fifo_data;
    end
  end

  logic unused_ok;
  assign unused_ok = fifo_ready ^ beat[0] ^ (|busy_vec);
endmodule

// File: sim/sdb_core_asserts.sv
module sdb_core_chk #(
  parameter int DATA_W = 16,
  parameter int COLS   = sdb_pkg::COL_X16
) (
  input wire logic              core_clk_i,      // Clock
  input wire logic              reset_i,         // Sync reset
  input wire logic              power_down_i,    // Sleep request
  input wire sdb_pkg::sdb_req_t req_i,           // Command
  input wire logic [DATA_W-1:0] wr_data_i,       // Write data
  input wire logic [DATA_W-1:0] rd_data_o,       // Read data
  input wire logic              rd_valid_o,      // Read strobe
  input wire logic              cmd_ready_o,     // Accepting
  input wire logic              in_power_down_o, // Asleep
  input wire logic              refreshing_o,    // Refreshing
  input wire logic [3:0]        bank_open_o      // Open rows
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Quiet time: all rows closed long enough for precharge
  // ----
  logic [3:0] idle_cnt;
  logic [1:0] bsel;
  assign bsel = {req_i.bank_select_hi, req_i.bank_select_lo};
  always_ff @(posedge core_clk_i) begin
    if (reset_i || bank_open_o != 4'h0) begin
      idle_cnt <= 4'h0;
    end else if (idle_cnt != 4'hf) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Command counts as taken only if ready spans the capture
  sequence s_take(sdb_pkg::sdb_cmd_t c);
    req_i.cmd == c && cmd_ready_o ##1 cmd_ready_o;
  endsequence
  property p_act_open;
    idle_cnt > 4'h7 ##0 s_take(sdb_pkg::SDB_CMD_ACTIVATE)
      |=> bank_open_o[$past(bsel, 2)];
  endproperty
  a_act_open: assert property (p_act_open)
    else $error("activate did not open its bank");
  property p_rd_closed;
    idle_cnt > 4'h7 ##0 s_take(sdb_pkg::SDB_CMD_READ) |=> !rd_valid_o [*6];
  endproperty
  a_rd_closed: assert property (p_rd_closed)
    else $error("read of closed bank returned data");
  property p_rd_lat;
    s_take(sdb_pkg::SDB_CMD_READ) ##0 bank_open_o[$past(bsel)]
      |-> ##[1:6] rd_valid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data late");
  property p_ref_refused;
    req_i.cmd == sdb_pkg::SDB_CMD_REFRESH && cmd_ready_o
      && bank_open_o != 4'h0 ##1 cmd_ready_o && bank_open_o != 4'h0
      |=> !refreshing_o [*3];
  endproperty
  a_ref_refused: assert property (p_ref_refused)
    else $error("refresh ran with a row open");
  property p_ref_run;
    idle_cnt > 4'h7 ##0 s_take(sdb_pkg::SDB_CMD_REFRESH)
      |-> ##[0:3] refreshing_o;
  endproperty
  a_ref_run: assert property (p_ref_run)
    else $error("refresh did not start");
  property p_ref_len;
    $rose(refreshing_o) |-> refreshing_o [*7] ##1 !refreshing_o;
  endproperty
  a_ref_len: assert property (p_ref_len)
    else $error("refresh length wrong");
  property p_ready;
    cmd_ready_o == !(refreshing_o || in_power_down_o);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready disagrees with busy state");
  property p_pd_cause;
    $rose(in_power_down_o) |-> $past(power_down_i);
  endproperty
  a_pd_cause: assert property (p_pd_cause)
    else $error("power-down without request");
endmodule
bind sdb_core sdb_core_chk #(.DATA_W(DATA_W), .COLS(COLS)) u_sdb_core_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .power_down_i(power_down_i),
  .req_i(req_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .cmd_ready_o(cmd_ready_o),
  .in_power_down_o(in_power_down_o), .refreshing_o(refreshing_o),
  .bank_open_o(bank_open_o));

// File: sim/sdb_ctrl_model.sv
module sdb_ctrl_model #(
  parameter int DATA_W = 16
) (
  input  wire logic              core_clk_i, // Clock
  output sdb_pkg::sdb_req_t      req_o,      // Command to memory
  output logic      [DATA_W-1:0] wr_data_o   // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic              wd_hold = 1'b0;
  logic [DATA_W-1:0] wd_word = '0;
  initial begin
    req_o = '0;
    wr_data_o = '0;
  end
  // One edge per request; write word follows its command by one cycle,
  // as the memory takes it; idle data toggles so stale words never match
  task automatic issue(input sdb_pkg::sdb_cmd_t c, input logic [1:0] b,
                       input logic [11:0] a, input logic ap,
                       input logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    req_o <= '{c, b[1], b[0], a, ap};
    wr_data_o <= wd_hold ? wd_word : ~wr_data_o;
    wd_hold = (c == sdb_pkg::SDB_CMD_WRITE);
    wd_word = d;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      req_o <= '0;
      wr_data_o <= wd_hold ? wd_word : ~wr_data_o;
      wd_hold = 1'b0;
    end
  endtask
  // Full refresh interval far exceeds the run; refresh is on demand
  task automatic refresh();
    issue(sdb_pkg::SDB_CMD_REFRESH, 2'h0, 12'h000, 1'b0, '0);
  endtask
endmodule

// File: sim/sdb_core_bench.sv
module sdb_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = 16;
  localparam int NCOL = sdb_pkg::COL_X16;
  typedef sdb_pkg::sdb_cmd_t sdb_tb_cmd_t;
  logic              core_clk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic              power_down_i = 1'b0;
  sdb_pkg::sdb_req_t req;
  logic [DW-1:0]     wr_data, rd_data;
  logic              rd_valid, cmd_ready, in_pd, refreshing;
  logic [3:0]        bank_open;
  int                num_errors = 0, compares = 0, cyc = 0;
  logic [DW-1:0]     rq[$];
  int                rc[$];
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (rd_valid === 1'b1) begin
      rq.push_back(rd_data);
      rc.push_back(cyc);
    end
  end
  sdb_core #(.DATA_W(DW), .COLS(NCOL)) u_sdb_core (
    .core_clk_i(core_clk_i), .reset_i(reset_i),
    .power_down_i(power_down_i), .req_i(req), .wr_data_i(wr_data),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .cmd_ready_o(cmd_ready),
    .in_power_down_o(in_pd), .refreshing_o(refreshing),
    .bank_open_o(bank_open));
  sdb_ctrl_model #(.DATA_W(DW)) u_sdb_ctrl_model (
    .core_clk_i(core_clk_i), .req_o(req), .wr_data_o(wr_data));
  // ----
  // Helpers
  // ----
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op(sdb_tb_cmd_t c, logic [1:0] b = 0, logic [11:0] a = 0,
                    logic ap = 0, logic [DW-1:0] d = 0);
    u_sdb_ctrl_model.issue(c, b, a, ap, d);
  endtask
  task automatic idle(int n);
    u_sdb_ctrl_model.idle(n);
  endtask
  function automatic logic [15:0] pat(int b, int c);
    return {4'ha, 2'b00, b[1:0], c[7:0]};
  endfunction
  task automatic await(ref logic s, input logic v, input string what);
    int i = 0;
    while (s !== v && i < 20) begin
      @(posedge core_clk_i);
      i++;
    end
    check(what, s, v);
  endtask
  // Close all, program mode, open bank 0 row 5
  task automatic setup(int code, int lat);
    op(sdb_pkg::SDB_CMD_PRECHARGE, 0, 0, 1);
    idle(4);
    op(sdb_pkg::SDB_CMD_MODE, 0, {6'h0, (lat == 3) ? 2'h3 : 2'h0, 1'b0,
       code[2:0]});
    op(sdb_pkg::SDB_CMD_ACTIVATE, 0, 12'h005);
    idle(3);
    rq.delete();
    rc.delete();
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_fill();
    int c;
    setup(0, 2);
    op(sdb_pkg::SDB_CMD_ACTIVATE, 1, 12'h005);
    idle(3);
    for (int i = 0; i < 20; i++) begin
      c = (i % 10 < 8) ? i % 10 : 246 + i % 10;
      op(sdb_pkg::SDB_CMD_WRITE, i / 10, c[11:0], 0, pat(i / 10, c));
    end
    idle(6);
  endtask
  task automatic t_len();
    for (int code = 0; code < 4; code++) begin
      setup(code, 2);
      op(sdb_pkg::SDB_CMD_READ, 0, 12'h0fe);
      idle(20);
      check("burst count", rq.size(), 1 << code);
      check("start word", rq[0], pat(0, 254));
      foreach (rq[k])
        check("burst word", rq[k], pat(0, (254 + k) % NCOL));
    end
    setup(4, 2);
    op(sdb_pkg::SDB_CMD_READ);
    idle(NCOL + 12);
    // Full-row burst wraps to its start column and keeps going
    check("full row count", rc[NCOL] - rc[0], NCOL);
    check("full row end", rq[NCOL - 1], pat(0, NCOL - 1));
    check("full row wrap", rq[NCOL], pat(0, 0));
    rq.delete();
    op(sdb_pkg::SDB_CMD_READ);
    idle(4);
    op(sdb_pkg::SDB_CMD_BURST_STOP);
    idle(12);
    check("stopped burst", rq.size() > 0 && rq.size() < 20, 1);
  endtask
  task automatic t_lat();
    int t[2];
    for (int l = 0; l < 2; l++) begin
      setup(0, l + 2);
      op(sdb_pkg::SDB_CMD_READ);
      t[l] = cyc;
      idle(10);
      check("latency word", rq[0], pat(0, 0));
      t[l] = rc[0] - t[l];
    end
    check("latency step", t[1] - t[0], 1);
  endtask
  task automatic t_rand();
    int n;
    setup(3, 2);
    op(sdb_pkg::SDB_CMD_READ, 0, 12'h004);
    op(sdb_pkg::SDB_CMD_READ, 0, 12'h002);
    op(sdb_pkg::SDB_CMD_READ, 0, 12'h000);
    idle(20);
    n = rq.size();
    for (int k = 0; k < 8; k++) check("cut burst", rq[n - 8 + k], pat(0, k));
  endtask
  task automatic t_bank();
    setup(2, 2);
    op(sdb_pkg::SDB_CMD_ACTIVATE, 1, 12'h005);
    idle(3);
    op(sdb_pkg::SDB_CMD_READ, 0, 12'h000, 1);
    idle(4);
    op(sdb_pkg::SDB_CMD_READ, 1, 12'h004);
    idle(20);
    check("two bank count", rq.size(), 8);
    for (int k = 0; k < 4; k++) begin
      check("bank0 word", rq[k], pat(0, k));
      check("bank1 word", rq[k + 4], pat(1, k + 4));
    end
    check("self close", bank_open, 4'h2);
  endtask
  task automatic t_ref();
    op(sdb_pkg::SDB_CMD_PRECHARGE, 0, 0, 1);
    idle(14);
    rq.delete();
    op(sdb_pkg::SDB_CMD_READ, 2, 12'h000);
    idle(12);
    check("closed read", rq.size(), 0);
    op(sdb_pkg::SDB_CMD_ACTIVATE, 0, 12'h005);
    idle(3);
    u_sdb_ctrl_model.refresh();
    idle(3);
    check("refresh refused", refreshing, 1'b0);
    op(sdb_pkg::SDB_CMD_PRECHARGE, 0, 0, 1);
    idle(14);
    u_sdb_ctrl_model.refresh();
    idle(1);
    await(refreshing, 1'b1, "refresh start");
    await(refreshing, 1'b0, "refresh end");
    check("ready after refresh", cmd_ready, 1'b1);
  endtask
  task automatic t_pd();
    @(posedge core_clk_i) power_down_i <= 1'b1;
    await(in_pd, 1'b1, "power down");
    check("ready asleep", cmd_ready, 1'b0);
    @(posedge core_clk_i) power_down_i <= 1'b0;
    await(in_pd, 1'b0, "wake");
  endtask
  // Latency 3 holds words an extra cycle in the read FIFO
  task automatic t_fifo();
    setup(3, 3);
    op(sdb_pkg::SDB_CMD_READ, 0, 12'h0fe);
    idle(20);
    check("fifo count", rq.size(), 8);
    foreach (rq[k])
      check("fifo order", rq[k], pat(0, (254 + k) % NCOL));
    check("fifo stream", rc[7] - rc[0], 7);
  endtask
  task automatic final_report();
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_fill();
    t_len();
    t_lat();
    t_rand();
    t_bank();
    t_ref();
    t_pd();
    t_fifo();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    final_report();
  end
endmodule
